/* File: rtl/usdp_cfg.svh */
// Constants of the shadow data port: addresses, field positions, reset values, timing.
// Assumes a 40 MHz bus clock and the AHB-Lite slave in usdp_shadow_port.
// Function
// - Sixteen word-spaced shadow locations alias receive buffer on read, transmit holding on write.
// - Each location carries the character in bits 7:0; bits 31:8 reserved, reset zero.
// - Received character comes from plain serial input, or infrared input in infrared mode.
// - Receive data is meaningful only while the character-valid flag is set.
// - FIFOs off: new character overwrites unread buffer and flags overrun.
// - FIFOs on: reading a shadow location returns and pops the receive FIFO head.
// - Receive FIFO full: keep contents, drop incoming character, flag overrun.
// - Transmit on plain serial output, or active-low infrared output in infrared mode.
// - FIFOs off and holding empty: one character write clears holding-empty flag.
// - FIFOs off: further writes before holding-empty returns replace pending character.
// - FIFOs on: transmit FIFO accepts up to its depth, sixteen, before full.
// - Write while transmit FIFO is full is discarded, contents untouched.
`ifndef USDP_CFG_SVH
`define USDP_CFG_SVH

`define USDP_SHADOW_BASE 32'h5000_1130
`define USDP_SHADOW_SPAN 32'h0000_0040
`define USDP_SHADOW7_ADDR 32'h5000_114C
`define USDP_SHADOW8_ADDR 32'h5000_1150
`define USDP_FCR_ADDR 32'h5000_1170
`define USDP_LSR_ADDR 32'h5000_1174
`define USDP_MODE_ADDR 32'h5000_1178

`define USDP_FCR_FIFO_EN_BIT 0
`define USDP_MODE_IR_BIT 0
`define USDP_LSR_DR_BIT 0
`define USDP_LSR_OE_BIT 1
`define USDP_LSR_TX_HOLDING_EMPTY_FLAG_BIT 5
`define USDP_LSR_TEMT_BIT 6

`define USDP_DATA_RESET 8'h00
`define USDP_RDATA_RESET 32'h0000_0000

`define USDP_CLK_HZ 40000000
`define USDP_BAUD_HZ 2500000
`define USDP_BAUD_DIV (`USDP_CLK_HZ / `USDP_BAUD_HZ)
`define USDP_TX_DEPTH 16
`define USDP_RX_DEPTH 4
`define USDP_CHAR_BITS 8

`endif

/* File: rtl/usdp_pkg.sv */
// Types shared by the shadow data port modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package usdp_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} usdp_rx_state_t;
endpackage : usdp_pkg
`default_nettype wire

/* File: rtl/usdp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes DEPTH is a power of two and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module usdp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  fifo_depth_bound_a: assert property (cnt_q <= FULL_CNT)
    else $error("fifo count above depth");
  full_write_lost_a: assert property (
    !flush && in_valid && !in_ready && !out_ready |=> cnt_q == $past(cnt_q))
    else $error("write into full fifo changed its contents");
endmodule : usdp_fifo
`default_nettype wire

/* File: rtl/usdp_tx_shift.sv */
// Character serialiser: one start bit, eight data bits LSB first, one stop bit.
// Assumes bit_tick is a one-cycle pulse at the bit rate.
`timescale 1ns/1ps
`default_nettype none
module usdp_tx_shift (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_tick,
  input wire logic load_valid,
  input wire logic [7:0] load_data,
  output logic load_ready,
  output logic line_out,
  output logic busy
);
  logic [9:0] shreg_q;
  logic [3:0] cnt_q;
  logic line_q;
  wire load = load_valid & load_ready;

  assign load_ready = (cnt_q == 4'h0);
  assign busy = ~load_ready;
  assign line_out = line_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg_q <= 10'h3FF;
      cnt_q <= 4'h0;
      line_q <= 1'b1;
    end else if (load) begin
      shreg_q <= {1'b1, load_data, 1'b0};
      cnt_q <= 4'hA;
    end else if (bit_tick && busy) begin
      line_q <= shreg_q[0];
      shreg_q <= {1'b1, shreg_q[9:1]};
      cnt_q <= cnt_q - 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  idle_line_high_a: assert property (!busy && !$past(busy) |-> line_out)
    else $error("serial output not idle high");
endmodule : usdp_tx_shift
`default_nettype wire

/* File: rtl/usdp_shadow_port.sv */
// Shadow receive/transmit data port of a serial port, an AHB-Lite slave.
// Assumes one 40 MHz clock, word transfers, and a peer at the fixed bit rate.
`timescale 1ns/1ps
`default_nettype none
`include "usdp_cfg.svh"
module usdp_shadow_port
  import usdp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sin,
  input wire logic sir_in,
  output logic sout,
  output logic sir_out_n
);
  // Bus decode in the address phase.
  // A shadow read pops the receive side as soon as its address phase is taken,
  // so a master must not issue speculative reads of these locations.
  wire ap_valid = hsel & htrans[1] & hready;
  wire [31:0] sh_off = haddr - `USDP_SHADOW_BASE;
  wire ap_shadow = (sh_off < `USDP_SHADOW_SPAN) && (sh_off[1:0] == 2'b00);
  wire ap_fcr = (haddr == `USDP_FCR_ADDR);
  wire ap_lsr = (haddr == `USDP_LSR_ADDR);
  wire ap_mode = (haddr == `USDP_MODE_ADDR);
  wire rd_shadow = ap_valid & ~hwrite & ap_shadow;
  wire rd_lsr = ap_valid & ~hwrite & ap_lsr;

  // Write data phase.
  logic wr_pend_q;
  logic wr_shadow_q;
  logic wr_fcr_q;
  logic wr_mode_q;
  wire wr_shadow = wr_pend_q & wr_shadow_q;
  wire wr_fcr = wr_pend_q & wr_fcr_q;
  wire wr_mode = wr_pend_q & wr_mode_q;
  wire [7:0] wr_char = hwdata[7:0];

  logic fifo_en_q;
  logic ir_q;
  logic [31:0] hrdata_q;
  wire fifo_en_d = hwdata[`USDP_FCR_FIFO_EN_BIT];
  wire fifo_flush = wr_fcr & (fifo_en_d != fifo_en_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_shadow_q <= 1'b0;
      wr_fcr_q <= 1'b0;
      wr_mode_q <= 1'b0;
    end else if (hready) begin
      wr_pend_q <= hsel & htrans[1] & hwrite;
      wr_shadow_q <= ap_shadow;
      wr_fcr_q <= ap_fcr;
      wr_mode_q <= ap_mode;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_en_q <= 1'b0;
      ir_q <= 1'b0;
    end else begin
      if (wr_fcr) begin
        fifo_en_q <= fifo_en_d;
      end
      if (wr_mode) begin
        ir_q <= hwdata[`USDP_MODE_IR_BIT];
      end
    end
  end

  // Bit-rate divider.
  logic [7:0] div_q;
  wire bit_tick = (div_q == 8'(`USDP_BAUD_DIV - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 8'h00;
    end else begin
      div_q <= bit_tick ? 8'h00 : div_q + 8'h01;
    end
  end

  // Receiver.
  // The line is sampled once per bit tick, so the peer must hold each bit for a
  // full tick period; there is no margin for a rate offset between the two ends.
  wire rx_line = ir_q ? ~sir_in : sin;
  usdp_rx_state_t rx_state_q;
  logic [7:0] rx_shreg_q;
  logic [2:0] rx_bit_q;
  wire rx_done = bit_tick & (rx_state_q == RX_STOP) & rx_line;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_q <= RX_IDLE;
      rx_shreg_q <= `USDP_DATA_RESET;
      rx_bit_q <= 3'h0;
    end else if (bit_tick) begin
      case (rx_state_q)
        RX_IDLE: begin
          rx_bit_q <= 3'h0;
          if (!rx_line) begin
            rx_state_q <= RX_DATA;
          end
        end
        RX_DATA: begin
          rx_shreg_q <= {rx_line, rx_shreg_q[7:1]};
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == 3'h7) begin
            rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: rx_state_q <= RX_IDLE;
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // Receive holding register for FIFO-off mode, receive FIFO for FIFO-on mode.
  logic [7:0] rbr_q;
  logic dr_q;
  logic oe_q;
  logic rxf_in_ready;
  logic rxf_out_valid;
  logic [7:0] rxf_out_data;
  wire rx_pop_nf = rd_shadow & ~fifo_en_q;
  wire rx_lost_nf = rx_done & ~fifo_en_q & dr_q & ~rx_pop_nf;
  wire rx_lost_f = rx_done & fifo_en_q & ~rxf_in_ready;
  wire char_valid = fifo_en_q ? rxf_out_valid : dr_q;
  wire [7:0] rx_char = fifo_en_q ? rxf_out_data : rbr_q;

  usdp_fifo #(.WIDTH(`USDP_CHAR_BITS), .DEPTH(`USDP_RX_DEPTH)) u_rx_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .flush(fifo_flush),
    .in_valid(rx_done & fifo_en_q),
    .in_data(rx_shreg_q),
    .in_ready(rxf_in_ready),
    .out_valid(rxf_out_valid),
    .out_data(rxf_out_data),
    .out_ready(rd_shadow & fifo_en_q)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rbr_q <= `USDP_DATA_RESET;
      dr_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      if (rx_done && !fifo_en_q) begin
        rbr_q <= rx_shreg_q;
        dr_q <= 1'b1;
      end else if (rx_pop_nf || fifo_flush) begin
        dr_q <= 1'b0;
      end
      // A loss in the same cycle as the status read keeps the flag set.
      if (rx_lost_nf || rx_lost_f) begin
        oe_q <= 1'b1;
      end else if (rd_lsr) begin
        oe_q <= 1'b0;
      end
    end
  end

  // Transmit holding register for FIFO-off mode, transmit FIFO for FIFO-on mode.
  // With FIFOs off the holding register feeds the shifter directly, and a write
  // that lands while a character is still pending replaces it.
  logic [7:0] thr_q;
  logic tx_holding_empty_flag_q;
  logic txf_out_valid;
  logic [7:0] txf_out_data;
  logic txf_in_ready;
  logic tx_load_ready;
  logic tx_busy;
  logic tx_line;
  wire tx_load_valid = fifo_en_q ? txf_out_valid : ~tx_holding_empty_flag_q;
  wire [7:0] tx_load_data = fifo_en_q ? txf_out_data : thr_q;
  wire tx_load = tx_load_valid & tx_load_ready;
  wire holding_empty = fifo_en_q ? ~txf_out_valid : tx_holding_empty_flag_q;

  usdp_fifo #(.WIDTH(`USDP_CHAR_BITS), .DEPTH(`USDP_TX_DEPTH)) u_tx_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .flush(fifo_flush),
    .in_valid(wr_shadow & fifo_en_q),
    .in_data(wr_char),
    .in_ready(txf_in_ready),
    .out_valid(txf_out_valid),
    .out_data(txf_out_data),
    .out_ready(tx_load_ready & fifo_en_q)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thr_q <= `USDP_DATA_RESET;
      tx_holding_empty_flag_q <= 1'b1;
    end else if (wr_shadow && !fifo_en_q) begin
      thr_q <= wr_char;
      tx_holding_empty_flag_q <= 1'b0;
    end else if ((tx_load && !fifo_en_q) || fifo_flush) begin
      tx_holding_empty_flag_q <= 1'b1;
    end
  end

  usdp_tx_shift u_tx_shift (
    .clk(hclk),
    .rst_n(hresetn),
    .bit_tick(bit_tick),
    .load_valid(tx_load_valid),
    .load_data(tx_load_data),
    .load_ready(tx_load_ready),
    .line_out(tx_line),
    .busy(tx_busy)
  );

  assign sout = ir_q ? 1'b1 : tx_line;
  assign sir_out_n = ir_q ? tx_line : 1'b1;

  // Read data are registered at the end of the address phase.
  wire [31:0] lsr_word = 32'(char_valid) << `USDP_LSR_DR_BIT
    | 32'(oe_q) << `USDP_LSR_OE_BIT
    | 32'(holding_empty) << `USDP_LSR_TX_HOLDING_EMPTY_FLAG_BIT
    | 32'(holding_empty & ~tx_busy) << `USDP_LSR_TEMT_BIT;
  wire [31:0] rd_data_d = ap_shadow ? {24'h00_0000, rx_char}
    : ap_lsr ? lsr_word
    : ap_fcr ? 32'(fifo_en_q)
    : ap_mode ? 32'(ir_q)
    : `USDP_RDATA_RESET;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `USDP_RDATA_RESET;
    end else if (ap_valid && !hwrite) begin
      hrdata_q <= rd_data_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence rx_on_unread_s;
    rx_done && !fifo_en_q && dr_q && !rx_pop_nf;
  endsequence

  sequence rx_start_s;
    bit_tick && rx_state_q == RX_IDLE && !rx_line;
  endsequence

  upper_bits_zero_a: assert property (rd_shadow |=> hrdata[31:8] == 24'h00_0000)
    else $error("reserved shadow bits not zero");
  nf_overrun_a: assert property (rx_on_unread_s |=> oe_q && rbr_q == $past(rx_shreg_q))
    else $error("overwrite without overrun");
  fifo_head_pop_a: assert property (
    rd_shadow && fifo_en_q && rxf_out_valid |=> hrdata[7:0] == $past(rxf_out_data))
    else $error("read did not return fifo head");
  full_rx_loss_a: assert property (rx_lost_f && !fifo_flush |=> oe_q)
    else $error("full receive fifo lost data without overrun");
  tx_holding_empty_flag_clear_a: assert property (wr_shadow && !fifo_en_q |=> !tx_holding_empty_flag_q)
    else $error("holding-empty not cleared by write");
  thr_replace_a: assert property (
    wr_shadow && !fifo_en_q |=> thr_q == $past(hwdata[7:0]))
    else $error("pending character not replaced");
  valid_flag_a: assert property (
    rx_done && !fifo_en_q && !wr_fcr |=> dr_q [*1] ##0 char_valid)
    else $error("received character not flagged valid");
  ir_idle_a: assert property (!ir_q |-> sir_out_n)
    else $error("infrared output active in normal mode");
  rx_start_a: assert property (rx_start_s |=> rx_state_q == RX_DATA)
    else $error("start bit not taken");
  ir_sout_idle_a: assert property (ir_q |-> sout)
    else $error("plain serial output active in infrared mode");
  rx_pop_clear_a: assert property (
    rd_shadow && !fifo_en_q && !rx_done && !wr_fcr |=> !char_valid)
    else $error("read character still flagged valid");
  rx_fifo_push_a: assert property (
    rx_done && fifo_en_q && rxf_in_ready && !fifo_flush |=> char_valid)
    else $error("received character not queued");
  overrun_clear_a: assert property (
    rd_lsr && !rx_lost_nf && !rx_lost_f |=> !oe_q)
    else $error("overrun flag not cleared by status read");
  tx_holding_empty_flag_set_a: assert property (
    tx_load && !fifo_en_q && !wr_shadow |=> tx_holding_empty_flag_q)
    else $error("holding-empty not set after load");
  tx_fifo_accept_a: assert property (
    wr_shadow && fifo_en_q && txf_in_ready |=> txf_out_valid)
    else $error("transmit fifo did not take a character");
  tx_full_drop_a: assert property (
    wr_shadow && fifo_en_q && !txf_in_ready && !tx_load_ready |=> !txf_in_ready)
    else $error("full transmit fifo changed level");
endmodule : usdp_shadow_port
`default_nettype wire

/* File: test/usdp_peer.sv */
// Serial peer model: sends and receives 8N1 frames at 16 clocks per bit.
// Assumes the port's fixed bit rate and that ir follows the port's infrared mode.
`timescale 1ns/1ps
`default_nettype none
module usdp_peer (
  input wire logic hclk,
  input wire logic ir,
  input wire logic sout,
  input wire logic sir_out_n,
  output logic sin,
  output logic sir_in
);
  logic [7:0] got[$];
  wire logic line_w = ir ? sir_out_n : sout;
  initial begin
    sin = 1'b1;
    sir_in = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      sin <= ir ? 1'b1 : f[i];
      sir_in <= ir ? ~f[i] : 1'b0;
      repeat (16) @(posedge hclk);
    end
  endtask : send
  // Samples each data bit in its middle: waits eight clocks into the start bit, then samples every 16 clocks.
  always begin
    logic [7:0] b;
    @(negedge line_w);
    repeat (8) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge hclk);
      b[i] = line_w;
    end
    repeat (16) @(posedge hclk);
    got.push_back(b);
  end
endmodule : usdp_peer
`default_nettype wire

/* File: test/test_uart_shadow_data_port.sv */
// Self-checking bench of the shadow data port with a serial peer model.
// Assumes the address map and line status layout of usdp_cfg.svh.
`timescale 1ns/1ps
`default_nettype none
`include "usdp_cfg.svh"
module test_uart_shadow_data_port;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic ir_mode = 1'b0;
  logic hreadyout, hresp, sin, sir_in, sout, sir_out_n;
  logic [31:0] hrdata, rd;
  logic [7:0] v[5];
  logic [7:0] txq[$];
  integer n_mismatch = 0;
  integer check_count = 0;
  integer seed = 94;
  always #12.5 hclk = ~hclk;
  usdp_shadow_port u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sin(sin), .sir_in(sir_in),
    .sout(sout), .sir_out_n(sir_out_n));
  usdp_peer u_peer (.hclk(hclk), .ir(ir_mode), .sout(sout), .sir_out_n(sir_out_n),
    .sin(sin), .sir_in(sir_in));
  task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_reg
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check_reg(what, exp, rd);
    check_reg("bus status", 32'h0000_0001, {30'h0, hresp, hreadyout});
  endtask : rd_chk
  // Any of the sixteen word-spaced aliases, picked at random.
  function automatic logic [31:0] sh();
    logic [3:0] k;
    k = 4'($random(seed));
    return `USDP_SHADOW_BASE + {26'h0, k, 2'b00};
  endfunction : sh
  // Upper data bits are random and must not disturb the character.
  task automatic tx(input logic [7:0] b);
    logic [31:0] r;
    r = $random(seed);
    txq.push_back(b);
    bus(1'b1, sh(), {r[31:8], b});
  endtask : tx
  task automatic wait_tx(input int n);
    for (int i = 0; i < 4000 && u_peer.got.size() < n; i++) @(posedge hclk);
    repeat (200) @(posedge hclk);
    while (txq.size() > 0 && u_peer.got.size() > 0)
      check_reg("tx byte", {24'h0, txq.pop_front()}, {24'h0, u_peer.got.pop_front()});
    check_reg("tx left", 32'h0, 32'(txq.size() + u_peer.got.size()));
  endtask : wait_tx
  task automatic finish_test;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #(25 * 30000);
    n_mismatch++;
    finish_test();
  end
  initial begin
    for (int i = 0; i < 5; i++) v[i] = 8'($random(seed));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("lsr", `USDP_LSR_ADDR, 32'h0000_0060);
    rd_chk("shadow7", `USDP_SHADOW7_ADDR, 32'h0000_0000);
    rd_chk("shadow8", `USDP_SHADOW8_ADDR, 32'h0000_0000);
    rd_chk("unmapped", 32'h5000_1200, 32'h0000_0000);
    u_peer.send(v[0]);
    repeat (4) @(posedge hclk);
    rd_chk("lsr", `USDP_LSR_ADDR, 32'h0000_0061);
    rd_chk("rx", sh(), {24'h0, v[0]});
    rd_chk("lsr", `USDP_LSR_ADDR, 32'h0000_0060);
    u_peer.send(v[1]);
    u_peer.send(v[2]);
    repeat (4) @(posedge hclk);
    rd_chk("lsr", `USDP_LSR_ADDR, 32'h0000_0063);
    rd_chk("rx", sh(), {24'h0, v[2]});
    ir_mode <= 1'b1;
    bus(1'b1, `USDP_MODE_ADDR, 32'h0000_0001);
    rd_chk("mode", `USDP_MODE_ADDR, 32'h0000_0001);
    u_peer.send(v[3]);
    repeat (4) @(posedge hclk);
    rd_chk("ir rx", sh(), {24'h0, v[3]});
    tx(v[4]);
    wait_tx(1);
    ir_mode <= 1'b0;
    bus(1'b1, `USDP_MODE_ADDR, 32'h0000_0000);
    tx(v[0]);
    repeat (4) @(posedge hclk);
    tx(v[1]);
    rd_chk("lsr", `USDP_LSR_ADDR, 32'h0000_0000);
    void'(txq.pop_back());
    tx(v[2]);
    wait_tx(2);
    bus(1'b1, `USDP_FCR_ADDR, 32'h0000_0001);
    rd_chk("fcr", `USDP_FCR_ADDR, 32'h0000_0001);
    for (int i = 0; i < 5; i++) u_peer.send(v[i]);
    repeat (4) @(posedge hclk);
    rd_chk("lsr", `USDP_LSR_ADDR, 32'h0000_0063);
    for (int i = 0; i < 4; i++) rd_chk("rx fifo", sh(), {24'h0, v[i]});
    rd_chk("lsr", `USDP_LSR_ADDR, 32'h0000_0060);
    for (int i = 0; i < 18; i++) tx(8'($random(seed)));
    void'(txq.pop_back());
    wait_tx(17);
    finish_test();
  end
endmodule : test_uart_shadow_data_port
`default_nettype wire
